// ===== shared/status_ind_pkg.sv
`default_nettype none
package status_ind_pkg;
  // Time base
  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned TICK_US        = 1000;
  localparam int unsigned TICK_CYCLES    = CLK_HZ / 1_000_000 * TICK_US;
  // Blink phase times in milliseconds
  localparam int unsigned SEARCH_HI_MS   = 200;
  localparam int unsigned SEARCH_LO_MS   = 1800;
  localparam int unsigned IDLE_HI_MS     = 1800;
  localparam int unsigned IDLE_LO_MS     = 200;
  localparam int unsigned XFER_HI_MS     = 125;
  localparam int unsigned XFER_LO_MS     = 125;
  // Least low time of the ring indicator
  localparam int unsigned RING_MIN_MS    = 120;
  localparam int unsigned MS_W           = 11;
  // Function level codes
  localparam logic [2:0]  FUN_MIN        = 3'h0;
  localparam logic [2:0]  FUN_FULL       = 3'h1;
  localparam logic [2:0]  FUN_AIR        = 3'h4;

  // Network state presented by the modem core
  typedef enum logic [1:0] {
    NET_OFF,
    NET_SEARCH,
    NET_IDLE,
    NET_XFER
  } net_state_t;

  // Operating mode derived from the function level and the pin
  typedef enum logic [1:0] {
    MODE_MIN,
    MODE_FULL,
    MODE_AIR
  } op_mode_t;

  // Radio control outputs travel together
  typedef struct packed {
    op_mode_t mode;
    logic     rf_en;
  } radio_t;
endpackage
`default_nettype wire

// ===== core/status_ind.sv
`timescale 1ns/1ps
`default_nettype none
module status_ind
  import status_ind_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES, // Cycles per millisecond
  parameter int unsigned N_PORTS  = 3            // Report output ports
)(
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               arst_n,
  // Core side
  input  wire logic               powered_on,
  input  wire net_state_t         net_state,
  input  wire logic [N_PORTS-1:0] urc_raise,
  input  wire logic               urc_sent,
  input  wire logic [2:0]         function_level_command,
  input  wire logic               fun_load,
  input  wire logic               airplane_pin_en,
  input  wire logic               cfg_load,
  input  wire logic               enter_low_power,
  // Pins
  input  wire logic               rf_disable_n,
  input  wire logic               low_power_wake_in,
  output var  logic               network_activity_led,
  output var  logic               status_out,
  output var  logic               ring_indicator_out,
  output var  logic               low_power_state_out,
  output var  radio_t             radio,
  // Register bus
  input  wire logic [3:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output var  logic [31:0]        reg_rdata,
  output var  logic               irq
);

  // ==========================================================
  // Register map
  localparam logic [3:0] A_STAT = 4'h0; // Sticky event status
  localparam logic [3:0] A_MASK = 4'h4; // Interrupt mask
  localparam logic [3:0] A_STATE = 4'h8; // Live state view
  localparam int unsigned EV_W  = 3;    // Report, wake, mode change

  // ==========================================================
  // Pin synchronisers
  logic [1:0] rfd_sync_q;   // RF-disable pin, two stages
  logic [1:0] wake_sync_q;  // Wake pin, two stages
  logic       rfd_n;        // Synchronised RF-disable
  logic       wake;         // Synchronised wake

  // Only stage two is read; stage one may be metastable
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rfd_sync_q  <= 2'h3;
      wake_sync_q <= 2'h0;
    end
    else
    begin
      rfd_sync_q  <= {rfd_sync_q[0], rf_disable_n};
      wake_sync_q <= {wake_sync_q[0], low_power_wake_in};
    end
  end
  assign rfd_n = rfd_sync_q[1];
  assign wake  = wake_sync_q[1];

  // ==========================================================
  // Millisecond tick
  logic [15:0] pre_q;  // Prescaler
  logic        ms_q;   // One-cycle tick pulse

  // Every phase counts whole milliseconds off this tick
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pre_q <= 16'h0000;
      ms_q  <= 1'b0;
    end
    else if (pre_q == 16'(TICK_CYC - 1))
    begin
      pre_q <= 16'h0000;
      ms_q  <= 1'b1;
    end
    else
    begin
      pre_q <= pre_q + 16'h0001;
      ms_q  <= 1'b0;
    end
  end

  // ==========================================================
  // Network activity blinker
  function automatic logic [MS_W-1:0] phase_len(net_state_t s,
                                                 logic hi);
    logic [MS_W-1:0] r;
    r = '0;
    case (s)
      NET_SEARCH: r = hi ? MS_W'(SEARCH_HI_MS) : MS_W'(SEARCH_LO_MS);
      NET_IDLE:   r = hi ? MS_W'(IDLE_HI_MS) : MS_W'(IDLE_LO_MS);
      NET_XFER:   r = hi ? MS_W'(XFER_HI_MS) : MS_W'(XFER_LO_MS);
      default:    r = '0;
    endcase
    return r;
  endfunction

  net_state_t      last_state_q;  // State seen last cycle
  logic [MS_W-1:0] blink_ms_q;    // Milliseconds spent in phase
  logic            blink_hi_q;    // Current phase level

  // A state change restarts the pattern on its high phase
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      last_state_q <= NET_OFF;
      blink_ms_q   <= '0;
      blink_hi_q   <= 1'b0;
    end
    else
    begin
      last_state_q <= net_state;
      if (net_state != last_state_q || net_state == NET_OFF)
      begin
        blink_ms_q <= '0;
        blink_hi_q <= (net_state != NET_OFF);
      end
      else if (ms_q)
      begin
        if (blink_ms_q == phase_len(net_state, blink_hi_q) - 1'b1)
        begin
          blink_ms_q <= '0;
          blink_hi_q <= !blink_hi_q;
        end
        else
          blink_ms_q <= blink_ms_q + 1'b1;
      end
    end
  end

  // ==========================================================
  // Status and activity outputs
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      status_out           <= 1'b0;
      network_activity_led <= 1'b0;
    end
    else
    begin
      status_out           <= powered_on;
      network_activity_led <= blink_hi_q;
    end
  end

  // ==========================================================
  // Ring indicator
  logic [7:0] ring_ms_q;   // Low time elapsed
  logic       ring_min_q;  // Least low time reached
  logic       sent_q;      // Report data has gone out

  // Any port raises the ring; it holds low until both the least
  // time has passed and the data went out. A new report restarts.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ring_indicator_out <= 1'b1;
      ring_ms_q          <= 8'h00;
      ring_min_q         <= 1'b0;
      sent_q             <= 1'b0;
    end
    else if (|urc_raise)
    begin
      ring_indicator_out <= 1'b0;
      ring_ms_q          <= 8'h00;
      ring_min_q         <= 1'b0;
      sent_q             <= urc_sent;
    end
    else if (!ring_indicator_out)
    begin
      if (urc_sent)
        sent_q <= 1'b1;
      if (ms_q && !ring_min_q)
      begin
        ring_ms_q <= ring_ms_q + 8'h01;
        if (ring_ms_q == 8'(RING_MIN_MS - 1))
          ring_min_q <= 1'b1;
      end
      if (ring_min_q && (sent_q || urc_sent))
        ring_indicator_out <= 1'b1;
    end
  end

  // ==========================================================
  // Function level and airplane pin control
  logic [2:0] fun_q;     // Requested function level
  logic       pin_en_q;  // Airplane pin control enabled
  radio_t     radio_d;   // Next radio state

  // Pin control stays off after reset until configured
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fun_q    <= FUN_FULL;
      pin_en_q <= 1'b0;
    end
    else
    begin
      if (fun_load)
        fun_q <= function_level_command;
      if (cfg_load)
        pin_en_q <= airplane_pin_en;
    end
  end

  // Unknown levels fall back to minimum, the safe radio-off mode
  always_comb
  begin
    radio_d = '{mode: MODE_MIN, rf_en: 1'b0};
    if (pin_en_q && !rfd_n)
      radio_d = '{mode: MODE_AIR, rf_en: 1'b0};
    else
      case (fun_q)
        FUN_FULL: radio_d = '{mode: MODE_FULL, rf_en: 1'b1};
        FUN_AIR:  radio_d = '{mode: MODE_AIR, rf_en: 1'b0};
        default:  radio_d = '{mode: MODE_MIN, rf_en: 1'b0};
      endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      radio <= '{mode: MODE_MIN, rf_en: 1'b0};
    else
      radio <= radio_d;
  end

  // ==========================================================
  // Low-power state
  // Wake wins over a same-cycle entry so the host is never missed
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      low_power_state_out <= 1'b0;
    else if (wake)
      low_power_state_out <= 1'b0;
    else if (enter_low_power)
      low_power_state_out <= 1'b1;
  end

  // ==========================================================
  // Event status, mask and register reads
  logic [EV_W-1:0] stat_q;  // Sticky events
  logic [EV_W-1:0] mask_q;  // Interrupt enables
  logic [EV_W-1:0] ev;      // This cycle's events

  assign ev = {radio_d != radio, wake && low_power_state_out,
               |urc_raise};

  // Set beats a write-one clear in the same cycle
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stat_q <= '0;
      mask_q <= '0;
    end
    else
    begin
      if (reg_wr && reg_addr == A_MASK)
        mask_q <= reg_wdata[EV_W-1:0];
      if (reg_wr && reg_addr == A_STAT)
        stat_q <= (stat_q & ~reg_wdata[EV_W-1:0]) | ev;
      else
        stat_q <= stat_q | ev;
    end
  end

  // Read data stands one cycle after the strobe; unmapped read zero
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_rdata <= 32'h0000_0000;
      irq       <= 1'b0;
    end
    else
    begin
      irq <= |(stat_q & mask_q);
      if (!reg_rd)
        reg_rdata <= 32'h0000_0000;
      else
        case (reg_addr)
          A_STAT:  reg_rdata <= {29'h0, stat_q};
          A_MASK:  reg_rdata <= {29'h0, mask_q};
          A_STATE: reg_rdata <= {24'h0, pin_en_q, low_power_state_out,
                                 ring_indicator_out, radio.mode,
                                 radio.rf_en, network_activity_led,
                                 status_out};
          default: reg_rdata <= 32'h0000_0000;
        endcase
    end
  end

  // ==========================================================
  // Checks
  a_pin_gated: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !pin_en_q && fun_q == FUN_FULL |=> radio.rf_en)
    else $error("RF dropped while pin control disabled");

  a_air_forced: assert property (@(posedge ref_clk) disable iff (!arst_n)
    pin_en_q && !rfd_n |=> radio.mode == MODE_AIR && !radio.rf_en)
    else $error("Pin low did not force airplane mode");

  a_fun_min: assert property (@(posedge ref_clk) disable iff (!arst_n)
    rfd_n && fun_q == FUN_MIN |=> radio.mode == MODE_MIN)
    else $error("Level zero did not give minimum mode");

  a_status_on: assert property (@(posedge ref_clk) disable iff (!arst_n)
    powered_on |=> status_out)
    else $error("Status not high while on");

  a_ring_fall: assert property (@(posedge ref_clk) disable iff (!arst_n)
    |urc_raise |=> !ring_indicator_out)
    else $error("Report did not pull ring low");

  a_ring_min: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $rose(ring_indicator_out) |-> $past(ring_min_q))
    else $error("Ring released before least low time");

  a_phase_reset: assert property (@(posedge ref_clk) disable iff (!arst_n)
    net_state != last_state_q && net_state != NET_OFF
      |=> blink_hi_q && blink_ms_q == '0)
    else $error("Pattern did not restart on state change");

  a_xfer_toggle: assert property (@(posedge ref_clk) disable iff (!arst_n)
    net_state == NET_XFER && last_state_q == NET_XFER && ms_q
      && blink_ms_q == MS_W'(XFER_HI_MS - 1) && $stable(net_state)
      |=> $changed(blink_hi_q))
    else $error("Transfer phase did not end at 125 ms");

  a_search_len: assert property (@(posedge ref_clk) disable iff (!arst_n)
    net_state == NET_SEARCH && blink_hi_q
      |-> blink_ms_q < MS_W'(SEARCH_HI_MS))
    else $error("Search high phase overran");

  a_idle_len: assert property (@(posedge ref_clk) disable iff (!arst_n)
    net_state == NET_IDLE && !blink_hi_q
      |-> blink_ms_q < MS_W'(IDLE_LO_MS))
    else $error("Idle low phase overran");

  a_wake_exit: assert property (@(posedge ref_clk) disable iff (!arst_n)
    wake |=> !low_power_state_out)
    else $error("Wake did not leave low power");

endmodule // status_ind
`default_nettype wire

// ===== verification/host_mcu.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Host pins and indicator LED watcher
module host_mcu (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  // Requests from the bench
  input  wire logic        rf_off,
  input  wire logic        wake_req,
  // Pins toward the device
  output var  logic        rf_disable_n,
  output var  logic        low_power_wake_in,
  input  wire logic        network_activity_led,
  // Last finished phase lengths in cycles
  output var  logic [31:0] hi_len,
  output var  logic [31:0] lo_len
);
  logic [31:0] run_q; // Cycles in the present level
  logic        led_q; // LED level one cycle ago
  // Pins move only after an edge, as a host port register does
  always_ff @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
    begin
      rf_disable_n      <= 1'b1;
      low_power_wake_in <= 1'b0;
    end
    else
    begin
      rf_disable_n      <= !rf_off;
      low_power_wake_in <= wake_req;
    end
  // A phase length is latched only once the level ends
  always_ff @(posedge ref_clk or negedge arst_n)
    if (!arst_n)
    begin
      run_q  <= 32'h0;
      led_q  <= 1'b0;
      hi_len <= 32'h0;
      lo_len <= 32'h0;
    end
    else
    begin
      led_q <= network_activity_led;
      if (network_activity_led === led_q)
        run_q <= run_q + 32'h1;
      else
      begin
        run_q <= 32'h1;
        if (led_q)
          hi_len <= run_q;
        else
          lo_len <= run_q;
      end
    end
endmodule // host_mcu
`default_nettype wire

// ===== verification/test_status_ind.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bench for the status indicator block
module test_status_ind
  import status_ind_pkg::*;
;
  localparam int T = 10; // Short millisecond for simulation
  logic ref_clk, arst_n, powered_on, urc_sent, fun_load, cfg_load;
  logic airplane_pin_en, enter_low_power, reg_wr, reg_rd, rf_off;
  logic wake_req, rf_disable_n, low_power_wake_in, led, stat, ring;
  logic lp, irq;
  logic [2:0] urc_raise, fun_lvl;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, hi_len, lo_len, rd;
  net_state_t net_state;
  radio_t radio;
  int num_errors = 0;
  int checks = 0;
  status_ind #(.TICK_CYC(T), .N_PORTS(3)) uut (.ref_clk(ref_clk),
    .arst_n(arst_n), .powered_on(powered_on), .net_state(net_state),
    .urc_raise(urc_raise), .urc_sent(urc_sent),
    .function_level_command(fun_lvl), .fun_load(fun_load),
    .airplane_pin_en(airplane_pin_en), .cfg_load(cfg_load),
    .enter_low_power(enter_low_power), .rf_disable_n(rf_disable_n),
    .low_power_wake_in(low_power_wake_in), .network_activity_led(led),
    .status_out(stat), .ring_indicator_out(ring),
    .low_power_state_out(lp), .radio(radio), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq));
  host_mcu host (.ref_clk(ref_clk), .arst_n(arst_n), .rf_off(rf_off),
    .wake_req(wake_req), .rf_disable_n(rf_disable_n),
    .low_power_wake_in(low_power_wake_in),
    .network_activity_led(led), .hi_len(hi_len), .lo_len(lo_len));
  // ========================================================
  // Clock, watchdog and shared tasks
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Whole run is near 50k cycles; 90k cycles means a hang
  initial
  begin
    #3_600_000;
    num_errors++;
    conclude();
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Range compare; equal bounds give an exact compare
  task automatic chk(input string nm, input int lo, input int hi,
                     input logic [31:0] got);
    checks++;
    if ((^got === 1'bx) || got < lo || got > hi)
    begin
      num_errors++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rdr(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic wait_led(input logic v);
    for (int n = 0; n < 40000 && led !== v; n++) tick(1);
  endtask
  // Pass through OFF so the first rise is a fresh phase
  task automatic blink(input net_state_t s, input int h, input int l);
    @(posedge ref_clk) net_state <= NET_OFF;
    tick(4);
    chk("led_off", 0, 0, led);
    @(posedge ref_clk) net_state <= s;
    wait_led(1'b1); wait_led(1'b0); wait_led(1'b1); tick(2);
    chk("hi_len", h * T - T, h * T + 2, hi_len);
    chk("lo_len", l * T - T, l * T + 2, lo_len);
  endtask
  task automatic radio_is(input op_mode_t m, input logic e);
    tick(5);
    chk("radio", {m, e}, {m, e}, radio);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ========================================================
  // Main sequence
  initial
  begin
    {arst_n, powered_on, urc_sent, fun_load, cfg_load, reg_wr} = 6'h0;
    {airplane_pin_en, enter_low_power, reg_rd, rf_off, wake_req} = 5'h0;
    urc_raise = 3'h0; fun_lvl = 3'h1; reg_addr = 4'h0;
    reg_wdata = 32'h0; net_state = NET_OFF;
    tick(12);
    chk("ring_rst", 1, 1, ring);
    @(posedge ref_clk) arst_n <= 1'b1;
    @(posedge ref_clk) powered_on <= 1'b1;
    tick(3);
    chk("status", 1, 1, stat);
    blink(NET_SEARCH, SEARCH_HI_MS, SEARCH_LO_MS);
    blink(NET_IDLE, IDLE_HI_MS, IDLE_LO_MS);
    blink(NET_XFER, XFER_HI_MS, XFER_LO_MS);
    // Pin is ignored until pin control is enabled
    @(posedge ref_clk) rf_off <= 1'b1;
    radio_is(MODE_FULL, 1'b1);
    @(posedge ref_clk) rf_off <= 1'b0;
    @(posedge ref_clk) begin fun_lvl <= 3'h0; fun_load <= 1'b1; end
    @(posedge ref_clk) fun_load <= 1'b0;
    radio_is(MODE_MIN, 1'b0);
    @(posedge ref_clk) begin fun_lvl <= 3'h4; fun_load <= 1'b1; end
    @(posedge ref_clk) fun_load <= 1'b0;
    radio_is(MODE_AIR, 1'b0);
    @(posedge ref_clk) begin fun_lvl <= 3'h1; fun_load <= 1'b1; end
    @(posedge ref_clk) begin fun_load <= 1'b0; cfg_load <= 1'b1;
      airplane_pin_en <= 1'b1; end
    @(posedge ref_clk) cfg_load <= 1'b0;
    radio_is(MODE_FULL, 1'b1);
    @(posedge ref_clk) rf_off <= 1'b1;
    radio_is(MODE_AIR, 1'b0);
    @(posedge ref_clk) rf_off <= 1'b0;
    radio_is(MODE_FULL, 1'b1);
    // Low power entry and wake from the host
    @(posedge ref_clk) enter_low_power <= 1'b1;
    @(posedge ref_clk) enter_low_power <= 1'b0;
    tick(1);
    chk("low_power", 1, 1, lp);
    @(posedge ref_clk) wake_req <= 1'b1;
    tick(3);
    @(posedge ref_clk) wake_req <= 1'b0;
    tick(3);
    chk("woken", 0, 0, lp);
    // Report on every port, interrupt masked then unmasked
    wr(4'h4, 32'h0); wr(4'h0, 32'h7);
    for (int p = 0; p < 3; p++)
    begin
      @(posedge ref_clk) urc_raise <= 3'h1 << p;
      @(posedge ref_clk) urc_raise <= 3'h0;
      #1 chk("ring_low", 0, 0, ring);
      tick(RING_MIN_MS * T + 80);
      chk("ring_held", 0, 0, ring);
      @(posedge ref_clk) urc_sent <= 1'b1;
      @(posedge ref_clk) urc_sent <= 1'b0;
      tick(3);
      chk("ring_back", 1, 1, ring);
    end
    chk("irq_masked", 0, 0, irq);
    rdr(4'h0, rd);
    chk("stat_rpt", 1, 1, rd[0]);
    wr(4'h4, 32'h1); tick(2);
    chk("irq_on", 1, 1, irq);
    wr(4'h0, 32'h1); tick(2);
    chk("irq_off", 0, 0, irq);
    rdr(4'hC, rd);
    chk("unmapped", 0, 0, rd);
    // Live view; the blinking LED bit is masked out
    rdr(4'h8, rd);
    chk("state", 'hAD, 'hAD, rd & 32'hFFFF_FFFD);
    conclude();
  end
endmodule // test_status_ind
`default_nettype wire
